//--- bench/mdsr_host_model.sv
`timescale 1ns/10ps
module mdsr_host_model
    import mdsr_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic [7:0]     rdData,
    input  wire logic           rdValid,
    output mdsr_pkg::mdsr_acc_s acc,
    output logic                clrCnt,
    output logic                clrErr
);
    initial
    begin
        acc = '0;
        clrCnt = 1'b0;
        clrErr = 1'b0;
    end
    // address held until the answer is taken
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(negedge ref_clk);
        acc.addr = a;
        acc.rdEn = 1'b1;
        @(negedge ref_clk);
        acc.rdEn = 1'b0;
        while (rdValid !== 1'b1 && n < 4)
        begin
            @(negedge ref_clk);
            n++;
        end
        d = (n < 4) ? rdData : 8'hxx;
    endtask
    task automatic write(input logic [7:0] a, input logic [7:0] v);
        @(negedge ref_clk);
        acc.addr = a;
        acc.wdata = v;
        acc.wrEn = 1'b1;
        @(negedge ref_clk);
        acc.wrEn = 1'b0;
        acc.wdata = ~v;
    endtask
    // one-cycle command pulse, count clear or error clear
    task automatic command(input bit cnt);
        @(negedge ref_clk);
        clrCnt = cnt;
        clrErr = !cnt;
        @(negedge ref_clk);
        clrCnt = 1'b0;
        clrErr = 1'b0;
    endtask
endmodule

//--- bench/motor_driver_status_regs_test.sv
`timescale 1ns/10ps
module motor_driver_status_regs_test;
    import mdsr_pkg::*;
    logic       ref_clk;
    logic       resetn;
    mdsr_prot_s prot;
    mdsr_meas_s meas;
    mdsr_acc_s  acc;
    logic [7:0] rdData;
    logic       rdValid;
    logic       errO;
    logic       errOe;
    logic       cmdQ;
    logic       clrCnt;
    logic       clrErr;
    wire logic  errLine;
    logic [15:0] thr;
    logic [7:0] expByte;
    int         numErrors;
    int         nCompared;
    int         seed;
    // pull-up on the open-drain line
    assign errLine = errOe ? errO : 1'b1;
    motor_driver_status_regs i_motor_driver_status_regs (
        .ref_clk(ref_clk), .resetn(resetn), .protIn(prot), .measIn(meas),
        .rippleThreshold(thr), .clearRippleCountCmd(clrCnt),
        .clearErrorsCmd(clrErr), .acc(acc), .rdData(rdData),
        .rdValid(rdValid), .errorOutN_o(errO), .errorOutN_oe(errOe),
        .clearRippleCountCmd_q(cmdQ));
    mdsr_host_model i_mdsr_host_model (.ref_clk(ref_clk), .rdData(rdData),
        .rdValid(rdValid), .acc(acc), .clrCnt(clrCnt), .clrErr(clrErr));
    always #50 ref_clk = ~ref_clk;
    function automatic logic [7:0] protExp(mdsr_prot_s p, logic por,
                                           logic done);
        logic f;
        f = p.stall | p.overcurrent | p.overvoltage | p.thermal;
        return {f, 1'b0, p.stall, p.overcurrent, p.overvoltage, p.thermal,
                por, done};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_mdsr_host_model.read(a, d);
        check(d, exp);
    endtask
    task automatic rip(input int n);
        repeat (n)
        begin
            @(negedge ref_clk) meas.ripple = 1'b1;
            @(negedge ref_clk) meas.ripple = 1'b0;
        end
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #(100 * 20000);
        numErrors++;
        finish_test();
    end
    initial
    begin
        seed = 90;
        ref_clk = 1'b0;
        resetn = 1'b0;
        prot = '0;
        meas = '0;
        thr = 16'h012c;
        repeat (20) @(negedge ref_clk);
        resetn = 1'b1;
        for (int a = 0; a < 6; a++)
            rd(8'(a), 8'h00);
        check({7'h00, errLine}, 8'h01);
        $display("test reset done");
        for (int i = 0; i < 24; i++)
        begin
            // single flags first, then random mixes
            prot = (i < 4) ? (5'h10 >> i) : 5'($random(seed));
            prot.supplyOk = 1'b0;
            repeat (2) @(negedge ref_clk);
            expByte = protExp(prot, 1'b0, 1'b0);
            rd(MDSR_OFS_PROT, expByte);
            check({7'h00, errLine},
                  {7'h00, ~expByte[MDSR_BIT_FAULT]});
        end
        prot = '0;
        $display("test protection done");
        for (int i = 0; i < 12; i++)
        begin
            meas.speed = 8'($random(seed));
            meas.voltage = (i == 0) ? 8'hE4 : (i == 1) ? 8'hFF
                                            : 8'($random(seed));
            meas.current = (i == 0) ? 8'hC0 : 8'($random(seed));
            repeat (2) @(negedge ref_clk);
            rd(MDSR_OFS_SPEED, meas.speed);
            rd(MDSR_OFS_VOLT, meas.voltage);
            rd(MDSR_OFS_CURR, meas.current);
        end
        $display("test measurement done");
        // clear before the supply is good must not set the bit
        i_mdsr_host_model.command(1'b0);
        rd(MDSR_OFS_PROT, 8'h00);
        prot.supplyOk = 1'b1;
        repeat (2) @(negedge ref_clk);
        rd(MDSR_OFS_PROT, 8'h00);
        i_mdsr_host_model.command(1'b0);
        rd(MDSR_OFS_PROT, 8'h02);
        $display("test power-on done");
        rip(300);
        rd(MDSR_OFS_CNT_LO, 8'h2c);
        rd(MDSR_OFS_CNT_HI, 8'h01);
        rd(MDSR_OFS_PROT, 8'h02);
        rip(1);
        rd(MDSR_OFS_PROT, 8'h03);
        rd(MDSR_OFS_CNT_LO, 8'h2d);
        rip(3);
        rd(MDSR_OFS_PROT, 8'h03);
        i_mdsr_host_model.command(1'b1);
        check({7'h00, cmdQ}, 8'h01);
        @(negedge ref_clk);
        check({7'h00, cmdQ}, 8'h00);
        rd(MDSR_OFS_CNT_LO, 8'h00);
        rd(MDSR_OFS_CNT_HI, 8'h00);
        rd(MDSR_OFS_PROT, 8'h02);
        // lower threshold: count must pass it, not just reach it
        thr = 16'h0002;
        rip(2);
        rd(MDSR_OFS_PROT, 8'h02);
        rip(1);
        rd(MDSR_OFS_PROT, 8'h03);
        i_mdsr_host_model.command(1'b1);
        rd(MDSR_OFS_PROT, 8'h02);
        rd(MDSR_OFS_CNT_LO, 8'h00);
        $display("test ripple done");
        for (int a = 0; a < 6; a++)
            i_mdsr_host_model.write(8'(a), 8'hA5);
        rd(MDSR_OFS_PROT, 8'h02);
        rd(MDSR_OFS_SPEED, meas.speed);
        rd(MDSR_OFS_CNT_HI, 8'h00);
        rd(MDSR_OFS_CURR, meas.current);
        rd(8'h20, 8'h00);
        $display("test writes done");
        finish_test();
    end
endmodule

//--- src/mdsr_pkg.sv
package mdsr_pkg;

    localparam logic [7:0] MDSR_OFS_PROT    = 8'h00;
    localparam logic [7:0] MDSR_OFS_SPEED   = 8'h01;
    localparam logic [7:0] MDSR_OFS_CNT_LO  = 8'h02;
    localparam logic [7:0] MDSR_OFS_CNT_HI  = 8'h03;
    localparam logic [7:0] MDSR_OFS_VOLT    = 8'h04;
    localparam logic [7:0] MDSR_OFS_CURR    = 8'h05;

    localparam int MDSR_BIT_FAULT   = 7;
    localparam int MDSR_BIT_STALL   = 5;
    localparam int MDSR_BIT_CURR    = 4;
    localparam int MDSR_BIT_VOLT    = 3;
    localparam int MDSR_BIT_HEAT    = 2;
    localparam int MDSR_BIT_POR     = 1;
    localparam int MDSR_BIT_DONE    = 0;

    localparam logic [7:0]  MDSR_RESET_BYTE = 8'h00;
    localparam logic [15:0] MDSR_RESET_CNT  = 16'h0000;
    localparam logic [7:0]  MDSR_VOLT_38V   = 8'hE4;
    localparam logic [7:0]  MDSR_CURR_FULL  = 8'hC0;
    localparam logic [7:0]  MDSR_CODE_MAX   = 8'hFF;

    // live protection conditions from the analog engines
    typedef struct packed {
        logic stall;
        logic overcurrent;
        logic overvoltage;
        logic thermal;
        logic supplyOk;
    } mdsr_prot_s;

    // measurement values from the ripple and regulation engines
    typedef struct packed {
        logic [7:0]  speed;
        logic        ripple;
        logic [7:0]  voltage;
        logic [7:0]  current;
    } mdsr_meas_s;

    // register access port: read strobe, address, write strobe and write data
    typedef struct packed {
        logic       rdEn;
        logic [7:0] addr;
        logic       wrEn;
        logic [7:0] wdata;
    } mdsr_acc_s;

    typedef enum logic [2:0]
    {
        MDSR_POR_IDLE  = 3'b001,
        MDSR_POR_LOW   = 3'b010,
        MDSR_POR_HIGH  = 3'b100
    } mdsr_por_e;

    function automatic logic [7:0] mdsr_sat8(input logic [7:0] v);
        mdsr_sat8 = (v > MDSR_CODE_MAX) ? MDSR_CODE_MAX : v;
    endfunction

endpackage

//--- src/mdsr_ripple_counter.sv
`timescale 1ns/10ps
module mdsr_ripple_counter
    import mdsr_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          resetn,
    input  wire logic          rippleEvt,
    input  wire logic          clearCnt,
    input  wire logic [15:0]   threshold,
    output logic      [15:0]   count,
    output logic               doneSet
);

    logic [15:0] countQ;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            countQ <= MDSR_RESET_CNT;
        else if (clearCnt)
            countQ <= MDSR_RESET_CNT;
        // saturate: a wrap would fake a small count below the threshold
        else if (rippleEvt && !(&countQ))
            countQ <= countQ + 16'h0001;
    end

    assign count   = countQ;
    // pulse-free level; the flag latch in the parent makes it sticky
    assign doneSet = (countQ > threshold) && !clearCnt;

endmodule

//--- src/motor_driver_status_regs.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - bit 7 of protection status is 1 while any fault is present.
// - the active-low error pin is pulled low exactly while bit 7 is 1.
// - bit 5 reports a detected motor stall.
// - bit 4 reports an overcurrent event, 0 otherwise.
// - bit 3 reports an overvoltage event, 0 otherwise.
// - bit 2 reports a thermal shutdown event, 0 otherwise.
// - bit 1 latches low at power-up, goes high after a clear-errors once the supply is good.
// - bit 0 latches high once the ripple count exceeds the threshold.
// - count-done stays set until the clear-ripple-count command.
// - offset 1 holds the 8-bit speed estimate.
// - offset 2 holds ripple count bits 7 to 0.
// - offset 3 holds ripple count bits 15 to 8.
// - offset 4 holds the linear motor voltage code.
// - offset 5 holds the linear motor current code.
// - every status register is zero after reset.
// - clear-ripple-count zeroes the counter, clears count-done, self-clears.
module motor_driver_status_regs
    import mdsr_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire mdsr_pkg::mdsr_prot_s  protIn,
    input  wire mdsr_pkg::mdsr_meas_s  measIn,
    input  wire logic [15:0]           rippleThreshold,
    input  wire logic                  clearRippleCountCmd,
    input  wire logic                  clearErrorsCmd,
    input  wire mdsr_pkg::mdsr_acc_s   acc,
    output logic [7:0]                 rdData,
    output logic                       rdValid,
    output logic                       errorOutN_o,
    output logic                       errorOutN_oe,
    output logic                       clearRippleCountCmd_q
);
    import mdsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  protStatus_q;
    logic [7:0]  speed_q;
    logic [15:0] rippleCount;
    logic [7:0]  voltage_q;
    logic [7:0]  current_q;
    logic        doneSet;
    logic        anyFault;
    mdsr_por_e   porState_q;
    logic [7:0]  rdData_d;

    ////////////////////////////////////////////////////////////////////////
    // command bit self-clears one cycle after the host sets it
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            clearRippleCountCmd_q <= 1'b0;
        else
            clearRippleCountCmd_q <= clearRippleCountCmd
                                     && !clearRippleCountCmd_q;
    end

    mdsr_ripple_counter u_counter
    (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .rippleEvt (measIn.ripple),
        .clearCnt  (clearRippleCountCmd_q),
        .threshold (rippleThreshold),
        .count     (rippleCount),
        .doneSet   (doneSet)
    );

    ////////////////////////////////////////////////////////////////////////
    // power-on flag sequencing
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            porState_q <= MDSR_POR_IDLE;
        else
            case (porState_q)
                MDSR_POR_IDLE:
                    if (protIn.supplyOk)
                        porState_q <= MDSR_POR_LOW;
                MDSR_POR_LOW:
                    if (clearErrorsCmd)
                        porState_q <= MDSR_POR_HIGH;
                MDSR_POR_HIGH:
                    porState_q <= MDSR_POR_HIGH;
                default:
                    porState_q <= MDSR_POR_IDLE;
            endcase
    end

    assign anyFault = protIn.stall | protIn.overcurrent
                      | protIn.overvoltage | protIn.thermal;

    ////////////////////////////////////////////////////////////////////////
    // protection summary byte; bit 6 reserved reads zero
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            protStatus_q <= MDSR_RESET_BYTE;
        else
        begin
            protStatus_q[MDSR_BIT_FAULT] <= anyFault;
            protStatus_q[6]              <= 1'b0;
            protStatus_q[MDSR_BIT_STALL] <= protIn.stall;
            protStatus_q[MDSR_BIT_CURR]  <= protIn.overcurrent;
            protStatus_q[MDSR_BIT_VOLT]  <= protIn.overvoltage;
            protStatus_q[MDSR_BIT_HEAT]  <= protIn.thermal;
            protStatus_q[MDSR_BIT_POR]   <= (porState_q == MDSR_POR_HIGH)
                                            || (porState_q == MDSR_POR_LOW
                                                && clearErrorsCmd);
            // set wins: doneSet already masked in the clearing cycle
            if (doneSet)
                protStatus_q[MDSR_BIT_DONE] <= 1'b1;
            else if (clearRippleCountCmd_q)
                protStatus_q[MDSR_BIT_DONE] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // open-drain pin enable registers anyFault directly, in step with the summary flag
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            errorOutN_o  <= 1'b0;
            errorOutN_oe <= 1'b0;
        end
        else
        begin
            errorOutN_o  <= 1'b0;
            errorOutN_oe <= anyFault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // measurement snapshots
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            speed_q   <= MDSR_RESET_BYTE;
            voltage_q <= MDSR_RESET_BYTE;
            current_q <= MDSR_RESET_BYTE;
        end
        else
        begin
            speed_q   <= measIn.speed;
            voltage_q <= mdsr_sat8(measIn.voltage);
            current_q <= mdsr_sat8(measIn.current);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; writes are never decoded so they cannot alter status
    always_comb
    begin
        rdData_d = MDSR_RESET_BYTE;
        case (acc.addr)
            MDSR_OFS_PROT:   rdData_d = protStatus_q;
            MDSR_OFS_SPEED:  rdData_d = speed_q;
            MDSR_OFS_CNT_LO: rdData_d = rippleCount[7:0];
            MDSR_OFS_CNT_HI: rdData_d = rippleCount[15:8];
            MDSR_OFS_VOLT:   rdData_d = voltage_q;
            MDSR_OFS_CURR:   rdData_d = current_q;
            default:         rdData_d = MDSR_RESET_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdData  <= MDSR_RESET_BYTE;
            rdValid <= 1'b0;
        end
        else
        begin
            rdValid <= acc.rdEn;
            if (acc.rdEn)
                rdData <= rdData_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // $past(resetn) skips the first edge, where $past still sees reset
    a_fault_summary: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $past(resetn) |-> protStatus_q[MDSR_BIT_FAULT] == $past(anyFault, 1))
        else $error("fault summary bit wrong");

    a_read_prot: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        acc.rdEn && acc.addr == MDSR_OFS_PROT
            |=> rdData == $past(protStatus_q, 1))
        else $error("protection status read wrong");

    a_pin_follows: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        errorOutN_oe == protStatus_q[MDSR_BIT_FAULT])
        else $error("error pin not matching summary");

    // open-drain: only ever pulls low, the pull-up gives the high level
    a_pin_low: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !errorOutN_o)
        else $error("error pin driven high");

    a_stall_bit: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $rose(protIn.stall) |=> protStatus_q[MDSR_BIT_STALL])
        else $error("stall bit not set");

    a_stall_clear: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $fell(protIn.stall) |=> !protStatus_q[MDSR_BIT_STALL])
        else $error("stall bit not cleared");

    a_event_bits: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $past(resetn) |-> {protStatus_q[MDSR_BIT_CURR],
            protStatus_q[MDSR_BIT_VOLT], protStatus_q[MDSR_BIT_HEAT]}
            == $past({protIn.overcurrent, protIn.overvoltage,
                      protIn.thermal}, 1))
        else $error("protection event bits wrong");

    a_overvolt_bit: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $rose(protIn.overvoltage) |=> protStatus_q[MDSR_BIT_VOLT])
        else $error("overvoltage bit not set");

    a_thermal_bit: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $rose(protIn.thermal) |=> protStatus_q[MDSR_BIT_HEAT])
        else $error("thermal bit not set");

    sequence s_por_armed;
        porState_q == MDSR_POR_LOW ##0 clearErrorsCmd;
    endsequence

    a_por_release: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        s_por_armed |=> protStatus_q[MDSR_BIT_POR] [*2])
        else $error("power-on flag not latched high");

    a_por_low: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        porState_q != MDSR_POR_HIGH |=> !protStatus_q[MDSR_BIT_POR]
            || $past(clearErrorsCmd, 1))
        else $error("power-on flag high too early");

    a_por_stays: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        protStatus_q[MDSR_BIT_POR] |=> protStatus_q[MDSR_BIT_POR])
        else $error("power-on flag dropped");

    sequence s_over_thr;
        rippleCount > rippleThreshold && !clearRippleCountCmd_q;
    endsequence

    a_done_set: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        s_over_thr |=> protStatus_q[MDSR_BIT_DONE])
        else $error("count-done not latched");

    a_done_sticky: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        protStatus_q[MDSR_BIT_DONE] && !clearRippleCountCmd_q
            |=> protStatus_q[MDSR_BIT_DONE])
        else $error("count-done dropped without clear");

    a_done_clear: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        clearRippleCountCmd_q |=> !protStatus_q[MDSR_BIT_DONE])
        else $error("count-done not cleared");

    sequence s_clear_req;
        clearRippleCountCmd && !clearRippleCountCmd_q;
    endsequence

    a_clear_steps: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        s_clear_req |=> clearRippleCountCmd_q ##1 (!clearRippleCountCmd_q
            && rippleCount == MDSR_RESET_CNT))
        else $error("clear-ripple-count steps wrong");

    a_clr_count: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        clearRippleCountCmd_q |=> rippleCount == MDSR_RESET_CNT
            && !clearRippleCountCmd_q)
        else $error("clear-ripple-count did not act");

    a_read_speed: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        acc.rdEn && acc.addr == MDSR_OFS_SPEED
            |=> rdData == $past(speed_q, 1))
        else $error("speed read wrong");

    a_speed_snap: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $past(resetn) |-> speed_q == $past(measIn.speed, 1))
        else $error("speed estimate not taken");

    a_read_low: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        acc.rdEn && acc.addr == MDSR_OFS_CNT_LO
            |=> rdValid && rdData == $past(rippleCount[7:0], 1))
        else $error("ripple low byte read wrong");

    a_read_count: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        acc.rdEn && acc.addr == MDSR_OFS_CNT_HI
            |=> rdValid && rdData == $past(rippleCount[15:8], 1))
        else $error("ripple high byte read wrong");

    a_read_volt: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        acc.rdEn && acc.addr == MDSR_OFS_VOLT
            |=> rdData == $past(voltage_q, 1))
        else $error("voltage read wrong");

    a_read_curr: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        acc.rdEn && acc.addr == MDSR_OFS_CURR
            |=> rdData == $past(current_q, 1))
        else $error("current read wrong");

    sequence s_reset_held;
        !resetn ##1 !resetn;
    endsequence

    a_reset_zero: assert property (
        @(posedge ref_clk) s_reset_held |-> protStatus_q == MDSR_RESET_BYTE
            && speed_q == MDSR_RESET_BYTE && voltage_q == MDSR_RESET_BYTE
            && current_q == MDSR_RESET_BYTE && rippleCount == MDSR_RESET_CNT
            && !rdValid && rdData == MDSR_RESET_BYTE)
        else $error("status not zero in reset");

    a_write_ignored: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        acc.wrEn && !acc.rdEn |=> !rdValid)
        else $error("write produced a read answer");

    a_read_none: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        acc.rdEn && acc.addr > MDSR_OFS_CURR
            |=> rdData == MDSR_RESET_BYTE)
        else $error("unmapped read not zero");

endmodule
